// *** core/brcl_pkg.sv ***
// Package for the bidirectional reset and start-up configuration latch.
// Assumes a 25 MHz CPU clock and a 32-bit AHB-Lite register bus.
package brcl_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_SYS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_LATCHED_CONFIG = 8'h04;
  localparam logic [7:0] OFS_BUS_CONFIG_ZERO = 8'h08;
  localparam logic [7:0] OFS_PORT_LOW = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_COMMAND = 8'h14;

  // System configuration field positions
  localparam int BIT_BIDIR_RESET_ENABLE = 3;
  localparam int BIT_POWERDOWN_CONFIG = 5;
  localparam int BIT_WRITE_CONFIG = 7;
  localparam int BIT_HIGH_BYTE_DISABLE = 9;

  // Bus configuration zero field positions
  localparam int BIT_BUS_TYPE_LO = 6;
  localparam int BIT_LATCH_LENGTHEN = 9;
  localparam int BIT_BUS_ACTIVE = 10;

  // Command register bits
  localparam int BIT_CMD_SOFT_RESET = 0;
  localparam int BIT_CMD_END_INIT = 1;

  // Status register field positions
  localparam int BIT_STAT_INIT_DONE = 0;
  localparam int BIT_STAT_KIND_LO = 1;
  localparam int BIT_STAT_ASYNC = 4;

  // Config port bit positions
  localparam int P0_WRITE_CONFIG = 8;
  localparam int P0_BUS_TYPE_LO = 6;

  // Sampling masks over the sixteen config port bits
  localparam logic [15:0] MASK_ALL = 16'hffff;
  localparam logic [15:0] MASK_SHORT = 16'h1fff;
  localparam logic [15:0] MASK_SOFT = 16'h1fc0;
  localparam logic [15:0] MASK_SOFT_CLEAR = 16'h003c;

  // Timing counts in CPU clock cycles
  localparam int SEQ_CYCLES = 512;
  localparam int SETTLE_CYCLES = 4;
  localparam int LATCH_CYCLES = 4;

  // Reset kinds
  typedef enum logic [2:0] {
    KIND_POWER_ON,
    KIND_LONG_HW,
    KIND_SHORT_HW,
    KIND_SOFTWARE,
    KIND_WATCHDOG
  } brcl_kind_e;

  // Latched configuration byte taken from the config port high byte
  typedef struct packed {
    logic [2:0] clock_option_field;
    logic [1:0] segment_addr_select;
    logic [1:0] chip_select_count;
    logic write_config_pin;
  } brcl_latch_s;

  // Pin levels after synchronisation
  typedef struct packed {
    logic reset_in_pin;
    logic powerdown_delay_pin;
    logic external_access_pin;
    logic [15:0] config_port;
  } brcl_pins_s;

endpackage : brcl_pkg

// *** core/brcl_pin_sync.sv ***
// Three-stage synchroniser with agreement filter for board pin levels.
// Assumes asynchronous pin inputs and one clock with synchronous reset.
`timescale 1ns/100ps
module brcl_pin_sync #(
  parameter int WIDTH = 19
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Raw and filtered levels
  input wire logic [WIDTH-1:0] raw_in,
  output logic [WIDTH-1:0] level_out
);

  if (WIDTH < 1) begin : g_chk
    $error("brcl_pin_sync: WIDTH must be at least 1");
  end

  // One three-flop chain per bit
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic s1; // First stage, read only by the second
    logic s2; // Second stage
    logic s3; // Third stage
    // Shift the chain; the level moves only when stages two and three agree
    always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
        s1 <= 1'b1;
        s2 <= 1'b1;
        s3 <= 1'b1;
        level_out[i] <= 1'b1;
      end else begin
        s1 <= raw_in[i];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          level_out[i] <= s3;
        end
      end
    end
  end

endmodule : brcl_pin_sync

// *** core/brcl_reset_latch.sv ***
// Reset pin control and start-up configuration latch with AHB-Lite registers.
// Assumes pins arrive asynchronously and the watchdog pulse is on clk_in.
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module brcl_reset_latch #(
  parameter int SEQ_LEN = brcl_pkg::SEQ_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [7:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  // Board pins
  input wire logic reset_in_pin_in,
  output logic reset_in_pin_out,
  output logic reset_in_pin_oe_out,
  output logic reset_out_pin_n_out,
  input wire logic powerdown_delay_pin_in,
  output logic powerdown_delay_pulldown_out,
  output logic powerdown_delay_pullup_out,
  input wire logic external_access_pin_in,
  input wire logic [15:0] config_port_in,
  // Core side
  input wire logic watchdog_overflow_in,
  output logic cpu_run_out,
  output brcl_pkg::brcl_latch_s latched_config_out
);

  if (SEQ_LEN < 2 || SEQ_LEN > 1023) begin : g_chk
    $error("brcl_reset_latch: SEQ_LEN must lie in 2..1023");
  end

  localparam logic [9:0] SEQ_LAST = 10'(SEQ_LEN - 1);
  localparam logic [9:0] SETTLE_LAST = 10'(brcl_pkg::SETTLE_CYCLES - 1);
  localparam logic [9:0] LATCH_LAST = 10'(brcl_pkg::LATCH_CYCLES - 1);

  typedef enum logic [2:0] {ST_SEQ, ST_SETTLE, ST_EXTEND, ST_LATCH, ST_RUN} brcl_state_e;

  brcl_pkg::brcl_pins_s pins; // Synchronised pin levels
  brcl_state_e state; // Reset sequencer state
  logic [9:0] count; // Cycle counter for the current state
  brcl_pkg::brcl_kind_e kind; // Kind of the running reset
  logic async_reset; // Running reset is asynchronous
  logic pin_seen_low; // Reset pin was low during the sequence
  logic init_done; // End-init command has completed
  logic bidir_reset_enable; // System config bit 3
  logic powerdown_config_bit; // System config bit 5
  logic write_config_bit; // Derived from config port
  logic high_byte_disable; // Derived from config port
  logic [1:0] bus_type_field; // Bus configuration zero bus type
  logic bus_active_bit; // Bus configuration zero bus active
  logic latch_lengthen_bit; // Bus configuration zero latch lengthen
  logic [15:0] port_latch; // Last latched config port image
  logic soft_reset_req; // Pending soft reset command
  logic end_init_req; // Pending end-init command
  logic bus_pend; // Data phase in progress
  logic bus_write; // Pending transfer is a write
  logic [7:0] bus_addr; // Pending transfer address
  logic [15:0] next_port; // Port image to latch now
  logic start_seq; // A trigger starts a sequence this cycle

  // Synchronise every board input
  brcl_pin_sync #(
    .WIDTH($bits(brcl_pkg::brcl_pins_s))
  ) u_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .raw_in({reset_in_pin_in, powerdown_delay_pin_in, external_access_pin_in, config_port_in}),
    .level_out(pins)
  );

  // Sampling mask for a reset kind
  function automatic logic [15:0] sample_mask(brcl_pkg::brcl_kind_e k, logic async_k);
    logic [15:0] m;
    m = brcl_pkg::MASK_ALL;
    if (!async_k) begin
      case (k)
        brcl_pkg::KIND_SHORT_HW: m = brcl_pkg::MASK_SHORT;
        brcl_pkg::KIND_SOFTWARE, brcl_pkg::KIND_WATCHDOG: m = brcl_pkg::MASK_SOFT;
        default: m = brcl_pkg::MASK_ALL;
      endcase
    end
    return m;
  endfunction : sample_mask

  // Bits that a kind clears rather than keeps
  function automatic logic [15:0] clear_mask(brcl_pkg::brcl_kind_e k, logic async_k);
    logic [15:0] m;
    m = 16'h0000;
    if (!async_k && (k == brcl_pkg::KIND_SOFTWARE || k == brcl_pkg::KIND_WATCHDOG)) begin
      m = brcl_pkg::MASK_SOFT_CLEAR;
    end
    return m;
  endfunction : clear_mask

  // Any trigger while running starts a sequence
  assign start_seq = (state == ST_RUN) &&
                     (!pins.reset_in_pin || watchdog_overflow_in || soft_reset_req);

  // Port image merged by the kind of reset
  always_comb begin
    next_port = (pins.config_port & sample_mask(kind, async_reset)) |
                (port_latch & ~sample_mask(kind, async_reset) &
                 ~clear_mask(kind, async_reset));
  end

  // Sequencer state and counter
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state <= ST_SEQ;
      count <= 10'h000;
    end else begin
      case (state)
        ST_SEQ: begin
          count <= count + 10'h001;
          if (count == SEQ_LAST) begin
            state <= ST_SETTLE;
            count <= 10'h000;
          end
        end
        ST_SETTLE: begin
          count <= count + 10'h001;
          if (count == SETTLE_LAST) begin
            state <= pins.reset_in_pin ? ST_LATCH : ST_EXTEND;
            count <= 10'h000;
          end
        end
        ST_EXTEND: begin
          if (pins.reset_in_pin) begin
            state <= ST_LATCH;
          end
        end
        ST_LATCH: begin
          count <= count + 10'h001;
          if (count == LATCH_LAST) begin
            state <= ST_RUN;
            count <= 10'h000;
          end
        end
        ST_RUN: begin
          if (start_seq) begin
            state <= ST_SEQ;
            count <= 10'h000;
          end
        end
        default: begin
          state <= ST_SEQ;
          count <= 10'h000;
        end
      endcase
    end
  end

  // Reset kind and asynchronous selection
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      kind <= brcl_pkg::KIND_POWER_ON;
      async_reset <= 1'b0;
      pin_seen_low <= 1'b0;
    end else if (start_seq) begin
      async_reset <= !pins.powerdown_delay_pin;
      pin_seen_low <= 1'b0;
      if (!pins.reset_in_pin) begin
        kind <= brcl_pkg::KIND_SHORT_HW;
      end else if (watchdog_overflow_in) begin
        kind <= brcl_pkg::KIND_WATCHDOG;
      end else begin
        kind <= brcl_pkg::KIND_SOFTWARE;
      end
    end else if (state != ST_RUN) begin
      // Low delay pin at power-on or under a low reset pin forces async
      if (!pins.powerdown_delay_pin && (kind == brcl_pkg::KIND_POWER_ON ||
          !pins.reset_in_pin || reset_in_pin_oe_out)) begin
        async_reset <= 1'b1;
      end
      if (state == ST_SEQ && !pins.reset_in_pin) begin
        pin_seen_low <= 1'b1;
      end
      // A pulled pin turns soft and watchdog resets into hardware ones
      if (state == ST_SETTLE && pin_seen_low && (kind == brcl_pkg::KIND_SOFTWARE ||
          kind == brcl_pkg::KIND_WATCHDOG)) begin
        kind <= brcl_pkg::KIND_SHORT_HW;
      end
      if (state == ST_EXTEND && kind != brcl_pkg::KIND_POWER_ON) begin
        kind <= brcl_pkg::KIND_LONG_HW;
      end
    end
  end

  // Open-drain pull of the reset input pin
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      reset_in_pin_out <= 1'b0;
      reset_in_pin_oe_out <= 1'b0;
    end else begin
      reset_in_pin_out <= 1'b0;
      if (start_seq) begin
        reset_in_pin_oe_out <= bidir_reset_enable;
      end else if (state != ST_SEQ || count == SEQ_LAST) begin
        // Release with the last sequence cycle so the pull spans exactly SEQ_LEN
        reset_in_pin_oe_out <= 1'b0;
      end else if (!pins.powerdown_delay_pin) begin
        reset_in_pin_oe_out <= 1'b0; // Async drop disables the pull
      end
    end
  end

  // Delay pin pull-down and pull-up
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      powerdown_delay_pulldown_out <= 1'b0;
      powerdown_delay_pullup_out <= 1'b0;
    end else begin
      powerdown_delay_pulldown_out <= !pins.reset_in_pin;
      powerdown_delay_pullup_out <= (state == ST_RUN) && !start_seq &&
                                    powerdown_config_bit;
    end
  end

  // Reset output, run flag and end-of-initialisation
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      reset_out_pin_n_out <= 1'b0;
      cpu_run_out <= 1'b0;
      init_done <= 1'b0;
    end else if (start_seq) begin
      reset_out_pin_n_out <= 1'b0;
      cpu_run_out <= 1'b0;
      init_done <= 1'b0;
    end else begin
      cpu_run_out <= (state == ST_RUN) || (state == ST_LATCH && count == LATCH_LAST);
      if (state == ST_RUN && end_init_req) begin
        reset_out_pin_n_out <= 1'b1;
        init_done <= 1'b1;
      end
    end
  end

  // Configuration latch at the end of each sequence
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      port_latch <= 16'h0000;
      latched_config_out <= '0;
      write_config_bit <= 1'b0;
      high_byte_disable <= 1'b0;
      bus_type_field <= 2'h0;
      bus_active_bit <= 1'b0;
      latch_lengthen_bit <= 1'b0;
    end else if (state == ST_LATCH && count == LATCH_LAST) begin
      port_latch <= next_port;
      latched_config_out <= brcl_pkg::brcl_latch_s'(next_port[15:8]);
      write_config_bit <= !next_port[brcl_pkg::P0_WRITE_CONFIG];
      high_byte_disable <= !next_port[brcl_pkg::P0_BUS_TYPE_LO + 1];
      bus_type_field <= next_port[brcl_pkg::P0_BUS_TYPE_LO +: 2];
      bus_active_bit <= pins.external_access_pin;
      latch_lengthen_bit <= pins.external_access_pin;
    end
  end

  // Software-written configuration and commands
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      bidir_reset_enable <= 1'b0;
      powerdown_config_bit <= 1'b0;
      soft_reset_req <= 1'b0;
      end_init_req <= 1'b0;
    end else begin
      soft_reset_req <= 1'b0;
      end_init_req <= 1'b0;
      if (bus_pend && bus_write && bus_addr == brcl_pkg::OFS_SYS_CONFIG) begin
        powerdown_config_bit <= hwdata_in[brcl_pkg::BIT_POWERDOWN_CONFIG];
        if (!init_done) begin
          bidir_reset_enable <= hwdata_in[brcl_pkg::BIT_BIDIR_RESET_ENABLE];
        end
      end
      if (bus_pend && bus_write && bus_addr == brcl_pkg::OFS_COMMAND) begin
        soft_reset_req <= hwdata_in[brcl_pkg::BIT_CMD_SOFT_RESET];
        end_init_req <= hwdata_in[brcl_pkg::BIT_CMD_END_INIT];
      end
      if (start_seq) begin
        bidir_reset_enable <= 1'b0;
      end
    end
  end

  // AHB-Lite slave with one wait state per transfer
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      bus_pend <= 1'b0;
      bus_write <= 1'b0;
      bus_addr <= 8'h00;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      hrdata_out <= 32'h0000_0000;
    end else if (bus_pend) begin
      bus_pend <= 1'b0;
      hreadyout_out <= 1'b1;
      hrdata_out <= 32'h0000_0000;
      if (!bus_write) begin
        case (bus_addr)
          brcl_pkg::OFS_SYS_CONFIG: begin
            hrdata_out[brcl_pkg::BIT_BIDIR_RESET_ENABLE] <= bidir_reset_enable;
            hrdata_out[brcl_pkg::BIT_POWERDOWN_CONFIG] <= powerdown_config_bit;
            hrdata_out[brcl_pkg::BIT_WRITE_CONFIG] <= write_config_bit;
            hrdata_out[brcl_pkg::BIT_HIGH_BYTE_DISABLE] <= high_byte_disable;
          end
          brcl_pkg::OFS_LATCHED_CONFIG: hrdata_out[7:0] <= latched_config_out;
          brcl_pkg::OFS_BUS_CONFIG_ZERO: begin
            hrdata_out[brcl_pkg::BIT_BUS_TYPE_LO +: 2] <= bus_type_field;
            hrdata_out[brcl_pkg::BIT_LATCH_LENGTHEN] <= latch_lengthen_bit;
            hrdata_out[brcl_pkg::BIT_BUS_ACTIVE] <= bus_active_bit;
          end
          brcl_pkg::OFS_PORT_LOW: hrdata_out[7:0] <= port_latch[7:0];
          brcl_pkg::OFS_STATUS: begin
            hrdata_out[brcl_pkg::BIT_STAT_INIT_DONE] <= init_done;
            hrdata_out[brcl_pkg::BIT_STAT_KIND_LO +: 3] <= kind;
            hrdata_out[brcl_pkg::BIT_STAT_ASYNC] <= async_reset;
          end
          default: hrdata_out <= 32'h0000_0000; // Unmapped reads as zero
        endcase
      end
    end else if (hsel_in && htrans_in[1] && hready_in) begin
      bus_pend <= 1'b1;
      bus_write <= hwrite_in;
      bus_addr <= {haddr_in[7:2], 2'b00};
      hreadyout_out <= 1'b0;
    end
  end

endmodule : brcl_reset_latch

// *** test/brcl_reset_latch_sva.sv ***
// Port checker for the reset pin control and configuration latch.
// Assumes it is bound to brcl_reset_latch and sees only its ports.
`timescale 1ns/100ps
module brcl_reset_latch_sva #(
  parameter int SEQ_LEN = 512
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Pins and core side
  input wire logic reset_in_pin_in,
  input wire logic reset_in_pin_out,
  input wire logic reset_in_pin_oe_out,
  input wire logic reset_out_pin_n_out,
  input wire logic powerdown_delay_pulldown_out,
  input wire logic powerdown_delay_pullup_out,
  input wire logic cpu_run_out,
  input wire brcl_pkg::brcl_latch_s latched_config_out
);
  logic [15:0] hold_cnt; // Cycles with the CPU held
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // Length of the current CPU hold
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || cpu_run_out) hold_cnt <= 16'h0000;
    else hold_cnt <= hold_cnt + 16'h0001;
  end
  property p_oe_low; reset_in_pin_oe_out |-> !reset_in_pin_out; endproperty
  a_oe_low: assert property (p_oe_low) else $error("pin enabled high");
  property p_oe_start; $rose(reset_in_pin_oe_out) |-> $fell(cpu_run_out); endproperty
  a_oe_start: assert property (p_oe_start) else $error("pull outside start");
  property p_no_fetch; cpu_run_out |-> !reset_in_pin_oe_out; endproperty
  a_no_fetch: assert property (p_no_fetch) else $error("pin pulled in run");
  property p_reset_out_pin; $fell(cpu_run_out) |-> !reset_out_pin_n_out; endproperty
  a_reset_out_pin: assert property (p_reset_out_pin) else $error("reset out not low");
  property p_hold_len; $rose(cpu_run_out) |-> hold_cnt >= SEQ_LEN; endproperty
  a_hold_len: assert property (p_hold_len) else $error("sequence too short");
  property p_pd_on; !reset_in_pin_in [*8] |-> powerdown_delay_pulldown_out; endproperty
  a_pd_on: assert property (p_pd_on) else $error("pull-down missing");
  property p_pd_off; reset_in_pin_in [*8] |-> !powerdown_delay_pulldown_out; endproperty
  a_pd_off: assert property (p_pd_off) else $error("pull-down stuck");
  property p_pullup;
    $rose(powerdown_delay_pullup_out) |-> cpu_run_out && $past(cpu_run_out);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up early");
  property p_latch_hold;
    cpu_run_out && $past(cpu_run_out) |-> $stable(latched_config_out);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch moved");
  c_pull: cover property ($rose(reset_in_pin_oe_out));
  c_pullup: cover property ($rose(powerdown_delay_pullup_out));
  c_pd: cover property ($rose(powerdown_delay_pulldown_out));
endmodule : brcl_reset_latch_sva

bind brcl_reset_latch brcl_reset_latch_sva #(.SEQ_LEN(SEQ_LEN)) u_sva (
  .clk_in, .reset_n_in, .reset_in_pin_in, .reset_in_pin_out, .reset_in_pin_oe_out,
  .reset_out_pin_n_out, .powerdown_delay_pulldown_out, .powerdown_delay_pullup_out,
  .cpu_run_out, .latched_config_out);

// *** test/brcl_board_model.sv ***
// Board reset circuitry: pin pull-up, push button, delay capacitor.
// Assumes the device pulls the pin through its open-drain enable.
`timescale 1ns/100ps
module brcl_board_model #(
  parameter int DISCHARGE = 64
) (
  // Clock
  input wire logic clk_in,
  // Device side
  input wire logic pin_oe_in,
  input wire logic pin_drive_in,
  input wire logic pulldown_in,
  input wire logic pullup_in,
  output logic pin_level_out,
  output logic delay_level_out,
  // Bench side
  input wire logic press_in,
  input wire logic preset_in,
  input wire logic preset_level_in
);
  int unsigned dis_cnt = 0; // Cycles of discharge so far
  // Pull-up holds the pin high unless button or open drain pulls it
  assign pin_level_out = !(press_in || (pin_oe_in && !pin_drive_in));
  // Capacitor: preset by bench, drained by a long pull-down, else charged by the pull-up
  always_ff @(posedge clk_in) begin
    if (preset_in) delay_level_out <= preset_level_in;
    else if (dis_cnt >= DISCHARGE) delay_level_out <= 1'b0;
    else if (pullup_in) delay_level_out <= 1'b1;
  end
  // Drain time grows while the weak pull-down is on
  always_ff @(posedge clk_in) begin
    if (pulldown_in) dis_cnt <= dis_cnt + 1;
    else dis_cnt <= 0;
  end
endmodule : brcl_board_model

// *** test/brcl_reset_latch_tb_top.sv ***
// Self-checking bench: bus master, board model and a queue of read results.
// Assumes package, design, checker and board model are compiled first.
`timescale 1ns/100ps
module brcl_reset_latch_tb_top;
  localparam int SEQ = 8; // Shortened sequence
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b000;
  logic [31:0] hwdata = 32'h0;
  logic hrdy, hresp, pin, pdrv, poe, rout_n, pd, pu, dly, run;
  logic [31:0] hrdata;
  logic ea;
  logic [15:0] cfg;
  logic wdog = 1'b0;
  logic press = 1'b0;
  logic pre = 1'b1;
  logic pre_lvl = 1'b0;
  brcl_pkg::brcl_latch_s latched;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] e, m;
  logic [15:0] lat, n;
  logic dphase = 1'b0;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  int oe_seen = 0;
  integer seed = 32'h4889d1b2;

  initial forever #20 clk_in = ~clk_in;

  brcl_reset_latch #(.SEQ_LEN(SEQ)) u_dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hrdy), .hreadyout_out(hrdy), .hresp_out(hresp), .hrdata_out(hrdata),
    .reset_in_pin_in(pin), .reset_in_pin_out(pdrv), .reset_in_pin_oe_out(poe),
    .reset_out_pin_n_out(rout_n), .powerdown_delay_pin_in(dly),
    .powerdown_delay_pulldown_out(pd), .powerdown_delay_pullup_out(pu),
    .external_access_pin_in(ea), .config_port_in(cfg), .watchdog_overflow_in(wdog),
    .cpu_run_out(run), .latched_config_out(latched));

  brcl_board_model #(.DISCHARGE(64)) u_board (
    .clk_in(clk_in), .pin_oe_in(poe), .pin_drive_in(pdrv), .pulldown_in(pd),
    .pullup_in(pu), .pin_level_out(pin), .delay_level_out(dly),
    .press_in(press), .preset_in(pre), .preset_level_in(pre_lvl));

  task automatic miss(input string s);
    fails++;
    $display("MISMATCH at %0t: %s", $time, s);
  endtask : miss

  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string s);
    samples_checked++;
    if (got !== want) miss(s);
  endtask : chk

  // One single transfer; address held until hready, then data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_in);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge clk_in); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_in); while (hrdy !== 1'b1);
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k);
    exp_q.push_back(x);
    msk_q.push_back(k);
    bus(a, 1'b0, 32'h0);
  endtask : rd

  // Wait for a reset sequence to run and the CPU to be let go
  task automatic wait_run;
    do @(negedge clk_in); while (run !== 1'b0);
    do @(negedge clk_in); while (run !== 1'b1);
  endtask : wait_run

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  // Read results: oldest note is compared when the data phase ends
  always @(posedge clk_in) begin
    if (dphase && hrdy === 1'b1) begin
      samples_checked++;
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      if (((hrdata ^ e) & m) !== 32'h0) miss("read data");
      if (hresp !== 1'b0) miss("bus response");
    end
    if (hrdy === 1'b1) dphase = hsel && htrans[1] && !hwrite;
  end

  // Cycles the reset pin is pulled by the device
  always @(negedge clk_in) if (poe === 1'b1) oe_seen++;

  // Hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end

  initial begin
    n = 16'($random(seed));
    cfg <= n;
    ea <= 1'($random(seed));
    lat = n;
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1'b1;
    wait_run();
    chk(rout_n, 1'b0, "reset out after power-on");
    rd(8'h10, 32'h10, 32'h1f);
    rd(8'h04, {24'h0, lat[15:8]}, 32'hff);
    rd(8'h08, {21'h0, ea, ea, 1'b0, lat[7:6], 6'h0}, 32'h6c0);
    rd(8'h00, {22'h0, ~lat[7], 1'b0, ~lat[8], 7'h0}, 32'h288);
    rd(8'h18, 32'h0, 32'hffffffff);
    pre_lvl <= 1'b1;
    bus(8'h00, 1'b1, 32'h28);
    pre <= 1'b0;
    rd(8'h00, 32'h28, 32'h28);
    // Soft reset with bidirectional reset on
    n = {lat[15:13], 13'($random(seed))};
    cfg <= n;
    lat = n;
    oe_seen = 0;
    bus(8'h14, 1'b1, 32'h1);
    wait_run();
    chk(32'(oe_seen), SEQ, "pull length");
    chk(rout_n, 1'b0, "reset out held");
    rd(8'h10, 32'h0, 32'h11);
    rd(8'h0c, {24'h0, lat[7:0]}, 32'hff);
    rd(8'h00, 32'h0, 32'h8);
    bus(8'h14, 1'b1, 32'h2);
    repeat (2) @(negedge clk_in);
    chk(rout_n, 1'b1, "reset out released");
    rd(8'h10, 32'h1, 32'h1);
    bus(8'h00, 1'b1, 32'h8);
    rd(8'h00, 32'h0, 32'h8);
    // Watchdog reset samples the narrow set
    n = 16'($random(seed));
    cfg <= n;
    lat = (lat & 16'he003) | (n & 16'h1fc0);
    oe_seen = 0;
    @(posedge clk_in);
    wdog <= 1'b1;
    @(posedge clk_in);
    wdog <= 1'b0;
    wait_run();
    chk(32'(oe_seen), 32'h0, "pull without enable");
    chk(rout_n, 1'b0, "reset out on watchdog");
    rd(8'h10, 32'h8, 32'h1f);
    rd(8'h04, {24'h0, lat[15:8]}, 32'hff);
    rd(8'h0c, {24'h0, lat[7:0]}, 32'hff);
    // Short press, capacitor charged
    n = {lat[15:13], 13'($random(seed))};
    cfg <= n;
    lat = n;
    @(posedge clk_in);
    press <= 1'b1;
    repeat (8) @(posedge clk_in);
    press <= 1'b0;
    wait_run();
    rd(8'h10, 32'h4, 32'h1f);
    rd(8'h0c, {24'h0, lat[7:0]}, 32'hff);
    // Long press drains the capacitor
    n = 16'($random(seed));
    cfg <= n;
    lat = n;
    @(posedge clk_in);
    press <= 1'b1;
    repeat (100) @(posedge clk_in);
    @(negedge clk_in);
    chk(pd, 1'b1, "delay pull-down on");
    repeat (100) @(posedge clk_in);
    press <= 1'b0;
    wait_run();
    repeat (2) @(negedge clk_in);
    chk(pd, 1'b0, "delay pull-down off");
    chk({24'h0, latched}, {24'h0, lat[15:8]}, "latched output");
    rd(8'h10, 32'h10, 32'h11);
    print_verdict();
  end
endmodule : brcl_reset_latch_tb_top
